// [ast_pkg.sv]
package ast_pkg;

   // Widths of the instruction word, data path and pointers
   localparam int INSTR_W = 14;
   localparam int DATA_W  = 8;
   localparam int PTR_W   = 16;
   localparam int FADDR_W = 7;
   localparam int OFS_W   = 6;
   localparam int MODE_W  = 2;
   localparam int NPTR    = 2;

   // Fixed opcodes
   localparam logic [INSTR_W-1:0] OPC_IDLE  = 14'h0000;
   localparam logic [INSTR_W-1:0] OPC_RESET = 14'h0001;

   // Masked opcode groups: word & mask == pattern
   localparam logic [INSTR_W-1:0] MSK_ST_DIR = 14'h3f80;
   localparam logic [INSTR_W-1:0] PAT_ST_DIR = 14'h0080;
   localparam logic [INSTR_W-1:0] MSK_ST_IND = 14'h3ff8;
   localparam logic [INSTR_W-1:0] PAT_ST_IND = 14'h0018;
   localparam logic [INSTR_W-1:0] MSK_ST_REL = 14'h3f80;
   localparam logic [INSTR_W-1:0] PAT_ST_REL = 14'h3f80;

   // Field positions inside the instruction word
   localparam int FADDR_LSB   = 0;
   localparam int MODE_LSB    = 0;
   localparam int OFS_LSB     = 0;
   localparam int IDX_BIT_IND = 2;
   localparam int IDX_BIT_REL = 6;

   // Pointer mode field encodings
   localparam logic [MODE_W-1:0] MODE_PRE_INC  = 2'h0;
   localparam logic [MODE_W-1:0] MODE_PRE_DEC  = 2'h1;
   localparam logic [MODE_W-1:0] MODE_POST_INC = 2'h2;
   localparam logic [MODE_W-1:0] MODE_POST_DEC = 2'h3;

   // File addresses of the two indirect windows
   localparam logic [FADDR_W-1:0] WIN0_ADDR = 7'h00;
   localparam logic [FADDR_W-1:0] WIN1_ADDR = 7'h01;

   // Reset values and pointer step
   localparam logic [PTR_W-1:0] PTR_RST  = 16'h0000;
   localparam logic [PTR_W-1:0] PTR_STEP = 16'h0001;
   localparam logic             CAUSE_FLAG_RST = 1'b1;

   // Decoded operation
   typedef enum logic [2:0] {
      OP_NONE,
      OP_IDLE,
      OP_RESET,
      OP_ST_DIR,
      OP_ST_IND,
      OP_ST_REL
   } ast_op_t;

endpackage

// [ast_ptr_if.sv]
`timescale 1ns/1ps
interface ast_ptr_if;
   import ast_pkg::*;

   logic [PTR_W-1:0]  ptr;      // Selected pointer value
   logic              rel;      // Relative-offset form
   logic [MODE_W-1:0] mode;     // Pointer mode field
   logic [OFS_W-1:0]  ofs;      // Signed offset literal
   logic [PTR_W-1:0]  ea;       // Effective store address
   logic [PTR_W-1:0]  nxt;      // Pointer value after the store

   modport calc (input ptr, input rel, input mode, input ofs,
                 output ea, output nxt);
   modport core (output ptr, output rel, output mode, output ofs,
                 input ea, input nxt);
endinterface

// [ast_ptr_calc.sv]
`timescale 1ns/1ps
module ast_ptr_calc (
   ast_ptr_if.calc pi                 // Pointer request and result
);
   import ast_pkg::*;

   // Step by one; 16-bit arithmetic wraps at both ends
   function automatic logic [PTR_W-1:0] ptr_step(
      input logic [PTR_W-1:0] p,
      input logic             down
   );
      ptr_step = down ? (p - PTR_STEP) : (p + PTR_STEP);
   endfunction

   // Sign extension of the offset literal, -32 to 31
   function automatic logic [PTR_W-1:0] ofs_sext(
      input logic [OFS_W-1:0] k
   );
      ofs_sext = {{(PTR_W-OFS_W){k[OFS_W-1]}}, k};
   endfunction

   // Address and pointer update; no flag is touched here
   always_comb begin
      pi.ea  = pi.ptr;
      pi.nxt = pi.ptr;
      if (pi.rel) begin
         pi.ea  = pi.ptr + ofs_sext(pi.ofs);
         pi.nxt = pi.ptr;
      end else begin
         unique case (pi.mode)
            MODE_PRE_INC: begin
               pi.ea  = ptr_step(pi.ptr, 1'b0);
               pi.nxt = ptr_step(pi.ptr, 1'b0);
            end
            MODE_PRE_DEC: begin
               pi.ea  = ptr_step(pi.ptr, 1'b1);
               pi.nxt = ptr_step(pi.ptr, 1'b1);
            end
            MODE_POST_INC: begin
               pi.ea  = pi.ptr;
               pi.nxt = ptr_step(pi.ptr, 1'b0);
            end
            MODE_POST_DEC: begin
               pi.ea  = pi.ptr;
               pi.nxt = ptr_step(pi.ptr, 1'b1);
            end
         endcase
      end
   end

endmodule

// [ast_store_ops.sv]
`timescale 1ns/1ps
// Summary of operation
// - Direct store copies accumulator, one cycle, flags kept.
// - Indirect store writes accumulator through selected pointer.
// - Mode field picks pre/post increment or decrement.
// - Address is pointer, plus one, minus one, or plus offset.
// - Pointer then steps, or stays for offset form.
// - Offset literal is signed, -32 through 31.
// - Window has no storage; access goes via pointer.
// - Pointers are 16 bits and wrap around.
// - Pointer stepping never changes any status flag.
// - Reset instruction resets device, clears reset flag.
module ast_store_ops (
   input  wire logic                        ref_clk,       // Core clock
   input  wire logic                        sys_rst,       // Device reset
   input  wire logic                        por_rst,       // Power-on reset
   input  wire logic                        instr_valid,   // Word present
   input  wire logic [ast_pkg::INSTR_W-1:0] instr,         // Opcode word
   input  wire logic [ast_pkg::DATA_W-1:0]  acc,           // Accumulator
   input  wire logic                        ptr_load_en,   // Pointer write
   input  wire logic                        ptr_load_sel,  // Which pointer
   input  wire logic [ast_pkg::PTR_W-1:0]   ptr_load_data, // New value
   input  wire logic                        sw_flag_set,   // Flag set by sw
   input  wire logic                        win_rd_en,     // Window read
   input  wire logic                        win_rd_sel,    // Which window
   output      logic                        file_wr_en,    // File write
   output      logic [ast_pkg::FADDR_W-1:0] file_wr_addr,  // File address
   output      logic [ast_pkg::DATA_W-1:0]  file_wr_data,  // File data
   output      logic                        ind_wr_en,     // Indirect write
   output      logic [ast_pkg::PTR_W-1:0]   ind_wr_addr,   // Full address
   output      logic [ast_pkg::DATA_W-1:0]  ind_wr_data,   // Indirect data
   output      logic                        win_rd_valid,  // Read address ok
   output      logic [ast_pkg::PTR_W-1:0]   win_rd_addr,   // Read address
   output      logic [ast_pkg::PTR_W-1:0]   ptr0,          // Pointer 0
   output      logic [ast_pkg::PTR_W-1:0]   ptr1,          // Pointer 1
   output      logic                        reset_instruction_flag, // Cause
   output      logic                        dev_reset_req, // Reset request
   output      logic                        status_hold,   // Flags untouched
   output      logic                        instr_done     // Op retired
);
   import ast_pkg::*;

   // Opcode classification shared by execution and retirement
   // Exact words are matched before the masked groups
   function automatic ast_op_t op_decode(
      input logic                 vld,
      input logic [INSTR_W-1:0]   w
   );
      op_decode = OP_NONE;
      if (vld) begin
         if (w == OPC_IDLE) begin
            op_decode = OP_IDLE;
         end else if (w == OPC_RESET) begin
            op_decode = OP_RESET;
         end else if ((w & MSK_ST_DIR) == PAT_ST_DIR) begin
            op_decode = OP_ST_DIR;
         end else if ((w & MSK_ST_IND) == PAT_ST_IND) begin
            op_decode = OP_ST_IND;
         end else if ((w & MSK_ST_REL) == PAT_ST_REL) begin
            op_decode = OP_ST_REL;
         end
      end
   endfunction

   // Pointer index bit sits at a different place per form
   function automatic logic ptr_index(
      input ast_op_t            op,
      input logic [INSTR_W-1:0] w
   );
      ptr_index = (op == OP_ST_REL) ? w[IDX_BIT_REL]
                                    : w[IDX_BIT_IND];
   endfunction

   // True for either window address; used only for direct stores
   function automatic logic is_window(
      input logic [FADDR_W-1:0] a
   );
      is_window = (a == WIN0_ADDR) || (a == WIN1_ADDR);
   endfunction

   logic [PTR_W-1:0]   ptrs [NPTR];    // The two indirect pointers
   logic               reset_pend;     // Waiting for device reset
   ast_op_t            op;
   logic               sel;
   logic [FADDR_W-1:0] faddr;
   logic               dir_win;
   logic               dir_win_sel;
   logic               ind_op;

   ast_ptr_if pi ();

   ast_ptr_calc u_calc (
      .pi (pi.calc)
   );

   // Decode; nothing is accepted once a reset is pending
   always_comb begin
      op          = op_decode(instr_valid && !reset_pend, instr);
      sel         = ptr_index(op, instr);
      faddr       = instr[FADDR_LSB +: FADDR_W];
      dir_win     = (op == OP_ST_DIR) && is_window(faddr);
      dir_win_sel = (faddr == WIN1_ADDR);
      ind_op      = (op == OP_ST_IND) || (op == OP_ST_REL);
   end

   // Pointer request to the address calculator
   always_comb begin
      pi.ptr  = sel ? ptrs[1] : ptrs[0];
      pi.rel  = (op == OP_ST_REL);
      pi.mode = instr[MODE_LSB +: MODE_W];
      pi.ofs  = instr[OFS_LSB +: OFS_W];
   end

   // Pointer registers; an instruction update beats a load
   // A same-edge load to the stepped pointer is lost,
   // so software keeps loads clear of such stores
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NPTR; i++) begin
            ptrs[i] <= PTR_RST;
         end
      end else begin
         for (int i = 0; i < NPTR; i++) begin
            if (ind_op && (sel == i[0])) begin
               ptrs[i] <= pi.nxt;
            end else if (ptr_load_en && (ptr_load_sel == i[0])) begin
               ptrs[i] <= ptr_load_data;
            end
         end
      end
   end

   assign ptr0 = ptrs[0];
   assign ptr1 = ptrs[1];

   // Direct store to an ordinary file register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         file_wr_en   <= 1'b0;
         file_wr_addr <= WIN0_ADDR;
         file_wr_data <= '0;
      end else begin
         file_wr_en <= (op == OP_ST_DIR) && !dir_win;
         if ((op == OP_ST_DIR) && !dir_win) begin
            file_wr_addr <= faddr;
            file_wr_data <= acc;
         end
      end
   end

   // Indirect store, and direct stores aimed at a window
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ind_wr_en   <= 1'b0;
         ind_wr_addr <= PTR_RST;
         ind_wr_data <= '0;
      end else begin
         ind_wr_en <= ind_op || dir_win;
         if (ind_op) begin
            ind_wr_addr <= pi.ea;
            ind_wr_data <= acc;
         end else if (dir_win) begin
            // Window has no storage; the pointer is left as is
            ind_wr_addr <= dir_win_sel ? ptrs[1] : ptrs[0];
            ind_wr_data <= acc;
         end
      end
   end

   // Window read translation for other instructions
   // Old pointer value wins over a same-edge update
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         win_rd_valid <= 1'b0;
         win_rd_addr  <= PTR_RST;
      end else begin
         win_rd_valid <= win_rd_en;
         if (win_rd_en) begin
            win_rd_addr <= win_rd_sel ? ptrs[1] : ptrs[0];
         end
      end
   end

   // Retirement: every op here is one cycle and leaves flags alone
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         instr_done  <= 1'b0;
         status_hold <= 1'b0;
      end else begin
         instr_done  <= (op != OP_NONE);
         // Stepping a pointer never feeds the zero or carry logic
         status_hold <= (op != OP_NONE);
      end
   end

   // Reset request holds until the device reset arrives
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reset_pend    <= 1'b0;
         dev_reset_req <= 1'b0;
      end else if (op == OP_RESET) begin
         reset_pend    <= 1'b1;
         dev_reset_req <= 1'b1;
      end
   end

   // Cause flag survives the device reset; only power-on restores it.
   // The instruction clear beats a software set in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (por_rst) begin
         reset_instruction_flag <= CAUSE_FLAG_RST;
      end else if (op == OP_RESET) begin
         reset_instruction_flag <= 1'b0;
      end else if (sw_flag_set) begin
         reset_instruction_flag <= 1'b1;
      end
   end

endmodule

// [ast_store_ops_chk.sv]
`timescale 1ns/1ps
module ast_store_chk (
   input wire logic                        ref_clk,       // Clock
   input wire logic                        sys_rst,       // Reset
   input wire logic                        instr_valid,   // Word present
   input wire logic [ast_pkg::INSTR_W-1:0] instr,         // Word
   input wire logic [ast_pkg::DATA_W-1:0]  acc,           // Accumulator
   input wire logic                        ptr_load_en,   // Load
   input wire logic                        win_rd_en,     // Window read
   input wire logic                        win_rd_sel,    // Window
   input wire logic                        file_wr_en,    // File write
   input wire logic [ast_pkg::FADDR_W-1:0] file_wr_addr,  // File addr
   input wire logic [ast_pkg::DATA_W-1:0]  file_wr_data,  // File data
   input wire logic                        ind_wr_en,     // Ind write
   input wire logic [ast_pkg::PTR_W-1:0]   ind_wr_addr,   // Ind addr
   input wire logic [ast_pkg::DATA_W-1:0]  ind_wr_data,   // Ind data
   input wire logic                        win_rd_valid,  // Read valid
   input wire logic [ast_pkg::PTR_W-1:0]   win_rd_addr,   // Read addr
   input wire logic [ast_pkg::PTR_W-1:0]   ptr0,          // Pointer 0
   input wire logic [ast_pkg::PTR_W-1:0]   ptr1,          // Pointer 1
   input wire logic                        reset_instruction_flag, // Cause
   input wire logic                        dev_reset_req, // Reset request
   input wire logic                        status_hold,   // Flags kept
   input wire logic                        instr_done     // Retired
);
   import ast_pkg::*;
   // A word only counts when no reset is pending
   logic tk;
   assign tk = instr_valid && !sys_rst && !dev_reset_req;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_word(logic [INSTR_W-1:0] m, logic [INSTR_W-1:0] p);
      tk && ((instr & m) == p);
   endsequence
   // Window addresses 0 and 1 are excluded: they go out indirectly
   a_direct_copy: assert property (
      s_word(MSK_ST_DIR, PAT_ST_DIR) ##0 (instr[6:1] != 6'h00) |=>
      file_wr_en && !ind_wr_en && file_wr_addr == $past(instr[6:0])
      && file_wr_data == $past(acc)) else $error("direct store wrong");
   a_preinc_wrap: assert property (
      s_word(14'h3fff, 14'h0018) |=> ind_wr_en
      && ind_wr_addr == $past(ptr0) + 16'h0001
      && ptr0 == $past(ptr0) + 16'h0001) else $error("pre-increment wrong");
   a_postdec_ptr1: assert property (
      s_word(14'h3fff, 14'h001f) |=> ind_wr_en
      && ind_wr_addr == $past(ptr1) && ind_wr_data == $past(acc)
      && ptr1 == $past(ptr1) - 16'h0001) else $error("post-decrement wrong");
   a_rel_offset: assert property (
      s_word(14'h3fc0, 14'h3f80) |=> ind_wr_en && $stable(ptr0)
      && ind_wr_addr == $past(ptr0) + {{10{$past(instr[5])}},
      $past(instr[5:0])}) else $error("relative store wrong");
   a_flags_kept: assert property (
      (file_wr_en || ind_wr_en) |-> status_hold && instr_done)
      else $error("store without flag hold");
   a_idle_quiet: assert property (
      s_word(14'h3fff, OPC_IDLE) ##0 !ptr_load_en |=> instr_done
      && !file_wr_en && !ind_wr_en && $stable(ptr0) && $stable(ptr1))
      else $error("idle word changed state");
   a_soft_reset: assert property (
      s_word(14'h3fff, OPC_RESET) |=> dev_reset_req && !reset_instruction_flag
      && instr_done) else $error("reset word not obeyed");
   a_reset_refuse: assert property (
      dev_reset_req |=> dev_reset_req && !file_wr_en && !ind_wr_en)
      else $error("word ran during pending reset");
   a_window_addr: assert property (
      win_rd_en |=> win_rd_valid && win_rd_addr ==
      ($past(win_rd_sel) ? $past(ptr1) : $past(ptr0)))
      else $error("window read address wrong");
endmodule
bind ast_store_ops ast_store_chk u_chk (.ref_clk, .sys_rst, .instr_valid,
   .instr, .acc, .ptr_load_en, .win_rd_en, .win_rd_sel, .file_wr_en,
   .file_wr_addr, .file_wr_data, .ind_wr_en, .ind_wr_addr, .ind_wr_data,
   .win_rd_valid, .win_rd_addr, .ptr0, .ptr1, .reset_instruction_flag,
   .dev_reset_req, .status_hold, .instr_done);

// [accumulator_store_and_soft_reset_ops_tb_top.sv]
`timescale 1ns/1ps
module accumulator_store_and_soft_reset_ops_tb_top;
   import ast_pkg::*;
   logic               ref_clk, sys_rst, por_rst, instr_valid, sw_flag_set;
   logic               ptr_load_en, ptr_load_sel, win_rd_en, win_rd_sel;
   logic [INSTR_W-1:0] instr;
   logic [DATA_W-1:0]  acc, file_wr_data, ind_wr_data;
   logic [FADDR_W-1:0] file_wr_addr;
   logic [PTR_W-1:0]   ptr_load_data, ind_wr_addr, win_rd_addr, ptr0, ptr1;
   logic               file_wr_en, ind_wr_en, win_rd_valid;
   logic               reset_instruction_flag;
   logic               dev_reset_req, status_hold, instr_done;
   int                 failures, comparisons;

   ast_store_ops dut (.ref_clk, .sys_rst, .por_rst, .instr_valid, .instr,
      .acc, .ptr_load_en, .ptr_load_sel, .ptr_load_data, .sw_flag_set,
      .win_rd_en, .win_rd_sel, .file_wr_en, .file_wr_addr, .file_wr_data,
      .ind_wr_en, .ind_wr_addr, .ind_wr_data, .win_rd_valid, .win_rd_addr,
      .ptr0, .ptr1, .reset_instruction_flag, .dev_reset_req,
      .status_hold, .instr_done);

   // 40 MHz core clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [PTR_W-1:0] exp,
                      input logic [PTR_W-1:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Inputs move 2 ns after the edge, away from sampling
   task automatic step;
      @(posedge ref_clk);
      #2;
   endtask

   // Valid stays up so words can follow back to back
   task automatic issue(input logic [INSTR_W-1:0] w,
                        input logic [DATA_W-1:0] a);
      instr_valid = 1'b1;
      instr = w;
      acc = a;
      step();
   endtask

   task automatic quiet;
      instr_valid = 1'b0;
      step();
   endtask

   // Two cycles so a following load never lands in the same step
   task automatic load(input logic sel, input logic [PTR_W-1:0] v);
      ptr_load_en = 1'b1;
      ptr_load_sel = sel;
      ptr_load_data = v;
      step();
      ptr_load_en = 1'b0;
      step();
   endtask

   task automatic t_direct;
      load(1'b0, 16'hbeef);
      issue(PAT_ST_DIR | 14'h0002, 8'ha5);
      chk("file_wr_en", 16'h0001, file_wr_en);
      chk("file_wr_addr", 16'h0002, file_wr_addr);
      issue(PAT_ST_DIR | 14'h007f, 8'h96);
      chk("file_wr_addr", 16'h007f, file_wr_addr);
      chk("file_wr_data", 16'h0096, file_wr_data);
      chk("status_hold", 16'h0001, status_hold);
      issue(PAT_ST_DIR, 8'h3c);
      chk("file_wr_en", 16'h0000, file_wr_en);
      chk("ind_wr_addr", 16'hbeef, ind_wr_addr);
      chk("ind_wr_data", 16'h003c, ind_wr_data);
      issue(OPC_IDLE, 8'hff);
      chk("instr_done", 16'h0001, instr_done);
      chk("ind_wr_en", 16'h0000, ind_wr_en);
      chk("ptr0", 16'hbeef, ptr0);
      quiet();
      chk("instr_done", 16'h0000, instr_done);
   endtask

   // Every mode on both pointers, each at the wrap boundary
   task automatic t_indirect;
      logic [PTR_W-1:0] p, ea, nx;
      logic [1:0]       m;
      for (int i = 0; i < 8; i++) begin
         m = i[1:0];
         p = m[0] ? 16'h0000 : 16'hffff;
         ea = (m == MODE_PRE_INC) ? p + 16'h0001 :
              (m == MODE_PRE_DEC) ? p - 16'h0001 : p;
         nx = m[0] ? p - 16'h0001 : p + 16'h0001;
         load(i[2], p);
         load(!i[2], 16'h1234);
         issue(PAT_ST_IND | {11'h000, i[2], m}, 8'h50 + 8'(i));
         chk("ind_wr_en", 16'h0001, ind_wr_en);
         chk("ind_wr_addr", ea, ind_wr_addr);
         chk("ind_wr_data", 16'h0050 + 16'(i), ind_wr_data);
         chk("pointer", nx, i[2] ? ptr1 : ptr0);
         chk("other", 16'h1234, i[2] ? ptr0 : ptr1);
         chk("status_hold", 16'h0001, status_hold);
         quiet();
      end
   endtask

   // Both ends of the offset range, each wrapping the address
   task automatic t_relative;
      logic [PTR_W-1:0] p;
      logic [5:0]       k;
      for (int j = 0; j < 2; j++) begin
         k = j[0] ? 6'h1f : 6'h20;
         p = j[0] ? 16'hfff0 : 16'h0010;
         load(j[0], p);
         issue(PAT_ST_REL | {7'h00, j[0], k}, 8'hc3);
         chk("ind_wr_addr", p + {{10{k[5]}}, k}, ind_wr_addr);
         chk("pointer", p, j[0] ? ptr1 : ptr0);
         quiet();
      end
   endtask

   task automatic t_window;
      load(1'b1, 16'h4321);
      win_rd_en = 1'b1;
      win_rd_sel = 1'b1;
      step();
      win_rd_en = 1'b0;
      chk("win_rd_valid", 16'h0001, win_rd_valid);
      chk("win_rd_addr", 16'h4321, win_rd_addr);
   endtask

   task automatic t_reset;
      chk("reset flag", 16'h0001, reset_instruction_flag);
      issue(OPC_RESET, 8'h00);
      chk("dev_reset_req", 16'h0001, dev_reset_req);
      chk("reset flag", 16'h0000, reset_instruction_flag);
      issue(PAT_ST_DIR | 14'h0010, 8'h77);
      chk("file_wr_en", 16'h0000, file_wr_en);
      quiet();
      sys_rst = 1'b1;
      step();
      sys_rst = 1'b0;
      step();
      chk("dev_reset_req", 16'h0000, dev_reset_req);
      chk("ptr1", 16'h0000, ptr1);
      chk("reset flag", 16'h0000, reset_instruction_flag);
      sw_flag_set = 1'b1;
      step();
      sw_flag_set = 1'b0;
      chk("reset flag", 16'h0001, reset_instruction_flag);
   endtask

   // Main sequence after a 16-cycle reset
   initial begin
      {sys_rst, por_rst, instr_valid, sw_flag_set} = 4'hc;
      {ptr_load_en, ptr_load_sel, win_rd_en, win_rd_sel} = 4'h0;
      {instr, acc, ptr_load_data} = '0;
      failures = 0;
      comparisons = 0;
      repeat (16) @(posedge ref_clk);
      #2;
      sys_rst = 1'b0;
      por_rst = 1'b0;
      step();
      t_direct();
      t_indirect();
      t_relative();
      t_window();
      t_reset();
      give_verdict();
   end

   // The tests need some 90 cycles; 400 means a hang
   initial begin
      #10000;
      failures++;
      give_verdict();
   end
endmodule
